// >>> include/usbsif_consts.svh
/*
  Register offsets, field positions and timing counts for the USB suspend,
  interrupt and frame-number block. Assumes a 125 MHz clock.
*/
`ifndef USBSIF_CONSTS_SVH
`define USBSIF_CONSTS_SVH

// Register offsets (byte index on the plain register port)
`define USBSIF_OFS_FRAME_LOW   4'h0
`define USBSIF_OFS_FRAME_HIGH  4'h1
`define USBSIF_OFS_EP0_DATA    4'h2
`define USBSIF_OFS_EP1_DATA    4'h3
`define USBSIF_OFS_EP2_DATA    4'h4
`define USBSIF_OFS_EP3_DATA    4'h5
`define USBSIF_OFS_STATUS      4'h6
`define USBSIF_OFS_CLOCK_CTRL  4'h7
`define USBSIF_OFS_IRQ_ENABLE  4'h8
`define USBSIF_OFS_EP_FLAGS    4'h9

// Status register fields
`define USBSIF_ST_IDLE_BIT     0
`define USBSIF_ST_RESUME_BIT   1
`define USBSIF_ST_RESET_BIT    2
`define USBSIF_ST_WAKE_BIT     3

// Clock control register fields
`define USBSIF_CC_CLKEN_BIT    0
`define USBSIF_CC_LOWPWR_BIT   1

// Interrupt enable register fields
`define USBSIF_IE_SOF_BIT      4
`define USBSIF_IE_RESET_BIT    5

`define USBSIF_EP_BASE         4'h2
`define USBSIF_FRAME_HIGH_W    3

// Idle time before suspend
`define USBSIF_IDLE_TIME_US    3000
`define USBSIF_CLK_MHZ         125
`define USBSIF_IDLE_CYCLES     (`USBSIF_IDLE_TIME_US * `USBSIF_CLK_MHZ)

`endif

// >>> include/usbsif_pkg.sv
/*
  Types shared by the USB suspend, interrupt and frame-number block.
  Assumes the consts header is included where offsets are needed.
*/
`default_nettype none
package usbsif_pkg;
  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_SUSPENDED,
    ST_LEAVING
  } usbsif_link_e;

  typedef struct packed {
    logic       sof_valid;
    logic [10:0] frame;
    logic       activity;
    logic       resume;
    logic       bus_reset;
  } usbsif_bus_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } usbsif_req_s;
endpackage
`default_nettype wire

// >>> hdl/usbsif_ep_mem.sv
/*
  Four byte-wide endpoint data ports with registered read data.
  Assumes one access per cycle from the register port.
*/
`default_nettype none
module usbsif_ep_mem (
  input  wire logic       clk,
  input  wire logic       wr,
  input  wire logic [1:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [1:0] raddr,
  output var  logic [7:0] rdata
);
  logic [7:0] mem_reg [4];

  // Contents undefined after reset
  always_ff @(posedge clk) begin
    if (wr) begin
      mem_reg[waddr] <= wdata;
    end
    rdata <= mem_reg[raddr];
  end
endmodule
`default_nettype wire

// >>> hdl/usbsif_idle_timer.sv
/*
  Bus idle timer: pulses once when no activity has been seen for the
  idle time. Assumes activity is a synchronous level or pulse.
*/
`default_nettype none
`include "usbsif_consts.svh"
module usbsif_idle_timer #(
  parameter int unsigned IDLE_CYCLES = `USBSIF_IDLE_CYCLES
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic activity,
  input  wire logic armed,
  output var  logic expired
);
  logic [19:0] cnt_reg;
  logic [19:0] cnt_next;
  logic        exp_next;

  always_comb begin
    cnt_next = cnt_reg;
    exp_next = 1'b0;
    if (activity || !armed) begin
      cnt_next = 20'h0;
    end else if (cnt_reg == 20'(IDLE_CYCLES)) begin
      exp_next = 1'b1;
      cnt_next = cnt_reg + 20'h1;
    end else if (cnt_reg < 20'(IDLE_CYCLES)) begin
      cnt_next = cnt_reg + 20'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg <= 20'h0;
      expired <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      expired <= exp_next;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/usbsif_top.sv
/*
  USB device status block: frame number capture, endpoint data ports,
  suspend/resume/remote wake-up and the USB interrupt toward the MCU.
  Assumes the serial engine supplies decoded bus events on clk.
*/
// Local design decisions: the placing of the registers and the plain strobed port.
`default_nettype none
`include "usbsif_consts.svh"
module usbsif_top #(
  parameter int unsigned IDLE_CYCLES = `USBSIF_IDLE_CYCLES
) (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire usbsif_pkg::usbsif_req_s req,
  output var  logic [7:0]           rdata,
  input  wire usbsif_pkg::usbsif_bus_s bus,
  input  wire logic                 global_irq_en,
  input  wire logic                 mcu_usb_irq_en,
  output var  logic                 usb_irq,
  output var  logic                 remote_wake_pulse,
  output var  logic                 usb_clock_enable,
  output var  logic                 low_power_idle
);
  usbsif_pkg::usbsif_link_e state_reg, state_next;
  logic [7:0]  frame_count_low_reg, frame_count_low_next;
  logic [2:0]  frame_count_high_reg, frame_count_high_next;
  logic        bus_idle_flag_reg, bus_idle_flag_next;
  logic        resume_flag_reg, resume_flag_next;
  logic        reset_flag_reg, reset_flag_next;
  logic        remote_wake_request_reg, remote_wake_request_next;
  logic        clk_en_reg, clk_en_next;
  logic        lowpwr_reg, lowpwr_next;
  logic [5:0]  irq_en_reg, irq_en_next;
  logic [3:0]  ep_flag_reg, ep_flag_next;
  logic        irq_next;
  logic        wake_next;
  logic [7:0]  rdata_next;
  logic [7:0]  rdata_reg;
  logic        ep_rd_pending_reg;
  logic [7:0]  ep_rdata;
  logic        idle_expired;
  logic        ep_hit;
  logic [1:0]  ep_idx;
  logic [3:0]  ep_access;

  function automatic logic is_ep(input logic [3:0] a);
    is_ep = (a >= `USBSIF_EP_BASE) && (a < `USBSIF_EP_BASE + 4'h4);
  endfunction

  assign ep_hit = is_ep(req.addr);
  assign ep_idx = 2'(req.addr - `USBSIF_EP_BASE);

  // Access flags per endpoint, one decoder per port
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ep
      assign ep_access[g] = (req.wr || req.rd) && ep_hit && (ep_idx == 2'(g));
    end
  endgenerate

  usbsif_ep_mem u_mem (
    .clk   (clk),
    .wr    (req.wr && ep_hit),
    .waddr (ep_idx),
    .wdata (req.wdata),
    .raddr (ep_idx),
    .rdata (ep_rdata)
  );

  usbsif_idle_timer #(.IDLE_CYCLES(IDLE_CYCLES)) u_idle (
    .clk      (clk),
    .srst     (srst),
    .activity (bus.activity || bus.sof_valid),
    .armed    (state_reg == usbsif_pkg::ST_ACTIVE),
    .expired  (idle_expired)
  );

  // Frame number capture
  always_comb begin
    frame_count_low_next  = frame_count_low_reg;
    frame_count_high_next = frame_count_high_reg;
    if (bus.sof_valid) begin
      frame_count_low_next  = bus.frame[7:0];
      frame_count_high_next = bus.frame[10:8];
    end
  end

  always_ff @(posedge clk) begin
    frame_count_low_reg  <= frame_count_low_next;
    frame_count_high_reg <= frame_count_high_next;
  end

  // Suspend state and flags
  always_comb begin
    state_next         = state_reg;
    bus_idle_flag_next = bus_idle_flag_reg;
    resume_flag_next   = resume_flag_reg;
    wake_next          = 1'b0;
    case (state_reg)
      usbsif_pkg::ST_ACTIVE: begin
        if (idle_expired) begin
          state_next         = usbsif_pkg::ST_SUSPENDED;
          bus_idle_flag_next = 1'b1;
        end
      end
      usbsif_pkg::ST_SUSPENDED: begin
        if (bus.resume) begin
          resume_flag_next = 1'b1;
          state_next       = usbsif_pkg::ST_LEAVING;
        end else if (remote_wake_request_reg) begin
          wake_next = 1'b1;
        end
      end
      usbsif_pkg::ST_LEAVING: begin
        if (bus.activity || bus.sof_valid) begin
          state_next         = usbsif_pkg::ST_ACTIVE;
          bus_idle_flag_next = 1'b0;
          resume_flag_next   = 1'b0;
        end
      end
      default: begin
        state_next = usbsif_pkg::ST_ACTIVE;
      end
    endcase
  end

  // Software control and flags
  always_comb begin
    clk_en_next              = clk_en_reg;
    lowpwr_next              = lowpwr_reg;
    irq_en_next              = irq_en_reg;
    remote_wake_request_next = remote_wake_request_reg;
    ep_flag_next             = ep_flag_reg;
    reset_flag_next          = reset_flag_reg;
    if (req.wr) begin
      case (req.addr)
        `USBSIF_OFS_CLOCK_CTRL: begin
          clk_en_next = req.wdata[`USBSIF_CC_CLKEN_BIT];
          lowpwr_next = req.wdata[`USBSIF_CC_LOWPWR_BIT];
        end
        `USBSIF_OFS_STATUS: begin
          remote_wake_request_next = req.wdata[`USBSIF_ST_WAKE_BIT];
          if (req.wdata[`USBSIF_ST_RESET_BIT]) begin
            reset_flag_next = 1'b0;
          end
        end
        `USBSIF_OFS_IRQ_ENABLE: begin
          irq_en_next = req.wdata[5:0];
        end
        `USBSIF_OFS_EP_FLAGS: begin
          ep_flag_next = ep_flag_reg & ~req.wdata[3:0];
        end
        default: begin
        end
      endcase
    end
    // Hardware sets win over software clears
    ep_flag_next = ep_flag_next | ep_access;
    if (bus.bus_reset) begin
      reset_flag_next = 1'b1;
    end
  end

  // Interrupt pulse and read data
  always_comb begin
    irq_next = 1'b0;
    if ((state_reg == usbsif_pkg::ST_ACTIVE && idle_expired) ||
        (state_reg == usbsif_pkg::ST_SUSPENDED && bus.resume)) begin
      irq_next = 1'b1;
    end
    if (bus.bus_reset && irq_en_reg[`USBSIF_IE_RESET_BIT]) begin
      irq_next = 1'b1;
    end
    if (|(ep_access & irq_en_reg[3:0])) begin
      irq_next = 1'b1;
    end
    if (bus.sof_valid && irq_en_reg[`USBSIF_IE_SOF_BIT]) begin
      irq_next = 1'b1;
    end
    irq_next = irq_next && global_irq_en && mcu_usb_irq_en;
    rdata_next = 8'h00;
    if (req.rd) begin
      case (req.addr)
        `USBSIF_OFS_FRAME_LOW:  rdata_next = frame_count_low_reg;
        `USBSIF_OFS_FRAME_HIGH: rdata_next = {5'h00, frame_count_high_reg};
        `USBSIF_OFS_STATUS: begin
          rdata_next = {4'h0, remote_wake_request_reg, reset_flag_reg,
                        resume_flag_reg, bus_idle_flag_reg};
        end
        `USBSIF_OFS_CLOCK_CTRL: rdata_next = {6'h00, lowpwr_reg, clk_en_reg};
        `USBSIF_OFS_IRQ_ENABLE: rdata_next = {2'h0, irq_en_reg};
        `USBSIF_OFS_EP_FLAGS:   rdata_next = {4'h0, ep_flag_reg};
        default:                rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg               <= usbsif_pkg::ST_ACTIVE;
      bus_idle_flag_reg       <= 1'b0;
      resume_flag_reg         <= 1'b0;
      reset_flag_reg          <= 1'b0;
      remote_wake_request_reg <= 1'b0;
      clk_en_reg              <= 1'b0;
      lowpwr_reg              <= 1'b0;
      irq_en_reg              <= 6'h00;
      ep_flag_reg             <= 4'h0;
      usb_irq                 <= 1'b0;
      remote_wake_pulse       <= 1'b0;
      usb_clock_enable        <= 1'b0;
      low_power_idle          <= 1'b0;
      ep_rd_pending_reg       <= 1'b0;
      rdata_reg               <= 8'h00;
    end else begin
      state_reg               <= state_next;
      bus_idle_flag_reg       <= bus_idle_flag_next;
      resume_flag_reg         <= resume_flag_next;
      reset_flag_reg          <= reset_flag_next;
      remote_wake_request_reg <= remote_wake_request_next;
      clk_en_reg              <= clk_en_next;
      lowpwr_reg              <= lowpwr_next;
      irq_en_reg              <= irq_en_next;
      ep_flag_reg             <= ep_flag_next;
      usb_irq                 <= irq_next;
      remote_wake_pulse       <= wake_next;
      usb_clock_enable        <= clk_en_next;
      // Low power only applies outside the active state (suspended or leaving)
      low_power_idle          <= lowpwr_next && (state_next != usbsif_pkg::ST_ACTIVE);
      ep_rd_pending_reg       <= req.rd && ep_hit;
      rdata_reg               <= rdata_next;
    end
  end

  // Endpoint reads take the memory's registered byte
  assign rdata = ep_rd_pending_reg ? ep_rdata : rdata_reg;

  a_idle_sets_flag: assert property (@(posedge clk) disable iff (srst)
    (state_reg == usbsif_pkg::ST_ACTIVE && idle_expired) |=>
      bus_idle_flag_reg && (usb_irq == $past(global_irq_en && mcu_usb_irq_en)))
    else $error("idle expiry did not set idle flag");
  a_resume_sets_flag: assert property (@(posedge clk) disable iff (srst)
    (state_reg == usbsif_pkg::ST_SUSPENDED && bus.resume) |=> resume_flag_reg)
    else $error("resume not flagged");
  a_flags_clear_together: assert property (@(posedge clk) disable iff (srst)
    $fell(bus_idle_flag_reg) |-> $fell(resume_flag_reg))
    else $error("suspend and resume flags cleared apart");
  a_wake_only_suspended: assert property (@(posedge clk) disable iff (srst)
    remote_wake_pulse |-> $past(state_reg) == usbsif_pkg::ST_SUSPENDED)
    else $error("wake pulse outside suspend");
  a_wake_on_request: assert property (@(posedge clk) disable iff (srst)
    (state_reg == usbsif_pkg::ST_SUSPENDED && remote_wake_request_reg && !bus.resume)
      |=> remote_wake_pulse)
    else $error("wake request ignored in suspend");
  a_ep_flag_set: assert property (@(posedge clk) disable iff (srst)
    |ep_access |=> (ep_flag_reg & $past(ep_access)) == $past(ep_access))
    else $error("endpoint access flag not set");
  a_irq_gated_global: assert property (@(posedge clk) disable iff (srst)
    usb_irq |-> $past(global_irq_en && mcu_usb_irq_en))
    else $error("interrupt without global enable");
  a_frame_high_zero: assert property (@(posedge clk) disable iff (srst)
    $past(req.rd && req.addr == `USBSIF_OFS_FRAME_HIGH) |-> rdata[7:3] == 5'h00)
    else $error("frame high upper bits not zero");
  a_frame_capture: assert property (@(posedge clk) disable iff (srst)
    bus.sof_valid |=> {frame_count_high_reg, frame_count_low_reg} == $past(bus.frame))
    else $error("frame number not captured");
  a_sof_irq: assert property (@(posedge clk) disable iff (srst)
    (bus.sof_valid && irq_en_reg[`USBSIF_IE_SOF_BIT] && global_irq_en && mcu_usb_irq_en)
      |=> usb_irq)
    else $error("sof interrupt missing");
  a_low_power_sel: assert property (@(posedge clk) disable iff (srst)
    low_power_idle == (lowpwr_reg && state_reg != usbsif_pkg::ST_ACTIVE))
    else $error("low power select outside suspend");
  a_reset_irq: assert property (@(posedge clk) disable iff (srst)
    (bus.bus_reset && irq_en_reg[`USBSIF_IE_RESET_BIT] && global_irq_en && mcu_usb_irq_en)
      |=> usb_irq && reset_flag_reg)
    else $error("bus reset interrupt missing");
  a_resume_read_only: assert property (@(posedge clk) disable iff (srst)
    $rose(resume_flag_reg) |-> $past(bus.resume))
    else $error("resume flag set without bus resume");
endmodule
`default_nettype wire

// >>> verif/usbsif_host_model.sv
/*
  Behavioural USB host at the decoded bus-event side of the block.
  Assumes the bench calls its tasks and sets alive and delay.
*/
`default_nettype none
module usbsif_host_model (
  input  wire logic                    clk,
  input  wire logic                    remote_wake_pulse,
  output var  usbsif_pkg::usbsif_bus_s bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        alive     = 1'b1;
  logic        answer    = 1'b1;
  int          delay     = 3;
  int          cnt       = 0;
  int          wcnt      = -1;
  logic        wake_prev = 1'b0;
  logic        act_r     = 1'b0;
  logic        res_r     = 1'b0;
  logic        sof_r     = 1'b0;
  logic        rst_r     = 1'b0;
  logic [10:0] frm_r     = 11'h000;

  // Keep-alive traffic and answer to a wake pulse
  always @(posedge clk) begin
    cnt <= (cnt == 9) ? 0 : cnt + 1;
    act_r <= alive && (cnt == 0);
    res_r <= 1'b0;
    wake_prev <= remote_wake_pulse;
    if (wcnt > 0) begin
      wcnt <= wcnt - 1;
    end else if (wcnt == 0) begin
      res_r <= 1'b1;
      wcnt <= -1;
    end else if (remote_wake_pulse && !wake_prev && answer) begin
      wcnt <= delay;
    end
  end

  // Frame field shows garbage outside a start-of-frame
  always_comb begin
    bus.sof_valid = sof_r;
    bus.frame     = sof_r ? frm_r : ~frm_r;
    bus.activity  = act_r;
    bus.resume    = res_r;
    bus.bus_reset = rst_r;
  end

  task automatic send_sof(input logic [10:0] f);
    @(posedge clk);
    sof_r <= 1'b1;
    frm_r <= f;
    @(posedge clk);
    sof_r <= 1'b0;
  endtask

  task automatic send_reset();
    @(posedge clk);
    rst_r <= 1'b1;
    @(posedge clk);
    rst_r <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> verif/usb_device_suspend_irq_frame_tb.sv
/*
  Self-checking bench for the USB status block: frames, endpoint flags,
  suspend, resume and wake-up. Assumes the host model in its own file.
*/
`default_nettype none
`include "usbsif_consts.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, g, e); end end
module usb_device_suspend_irq_frame_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    clk = 1'b0;
  logic                    srst = 1'b1;
  usbsif_pkg::usbsif_req_s req = '0;
  usbsif_pkg::usbsif_bus_s bus;
  logic [7:0]              rdata;
  logic                    glob = 1'b1;
  logic                    mcu_en = 1'b1;
  logic                    usb_irq;
  logic                    wake;
  logic                    clk_en;
  logic                    low_pwr;
  int                      fails = 0;
  int                      compares = 0;
  int                      irqs = 0;
  int                      cycles = 0;
  logic [7:0]              d;

  usbsif_top #(.IDLE_CYCLES(50)) dut (.clk(clk), .srst(srst), .req(req),
    .rdata(rdata), .bus(bus), .global_irq_en(glob), .mcu_usb_irq_en(mcu_en),
    .usb_irq(usb_irq), .remote_wake_pulse(wake), .usb_clock_enable(clk_en),
    .low_power_idle(low_pwr));
  usbsif_host_model host (.clk(clk), .remote_wake_pulse(wake), .bus(bus));

  initial begin
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (usb_irq === 1'b1) irqs++;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic wait_irq(input int c0, input int lim);
    for (int i = 0; i < lim && irqs == c0; i++) @(posedge clk);
  endtask

  task automatic t_frame();
    int c;
    host.send_sof(11'h5a3);
    rd_reg(`USBSIF_OFS_FRAME_LOW, d);
    `CHK(d, 8'ha3)
    rd_reg(`USBSIF_OFS_FRAME_HIGH, d);
    `CHK(d, 8'h05)
    host.send_sof(11'h7ff);
    rd_reg(`USBSIF_OFS_FRAME_HIGH, d);
    `CHK(d, 8'h07)
    wr_reg(`USBSIF_OFS_IRQ_ENABLE, 8'h10);
    c = irqs;
    host.send_sof(11'h001);
    wait_irq(c, 6);
    `CHK(irqs, c + 1)
    mcu_en <= 1'b0;
    host.send_sof(11'h002);
    repeat (6) @(posedge clk);
    `CHK(irqs, c + 1)
    mcu_en <= 1'b1;
    wr_reg(`USBSIF_OFS_IRQ_ENABLE, 8'h20);
    host.send_reset();
    wait_irq(c + 1, 6);
    `CHK(irqs, c + 2)
    rd_reg(`USBSIF_OFS_STATUS, d);
    `CHK(d[2], 1'b1)
  endtask

  task automatic t_endpoint();
    int c;
    wr_reg(`USBSIF_OFS_STATUS, 8'h04);
    rd_reg(`USBSIF_OFS_STATUS, d);
    `CHK(d[2], 1'b0)
    wr_reg(`USBSIF_OFS_IRQ_ENABLE, 8'h05);
    for (int i = 0; i < 4; i++) begin
      c = irqs;
      wr_reg(4'(`USBSIF_EP_BASE + i), 8'h30 + 8'(i));
      repeat (5) @(posedge clk);
      `CHK(irqs, c + ((i % 2 == 0) ? 1 : 0))
    end
    for (int i = 0; i < 4; i++) begin
      rd_reg(4'(`USBSIF_EP_BASE + i), d);
      `CHK(d, 8'h30 + 8'(i))
    end
    rd_reg(`USBSIF_OFS_EP_FLAGS, d);
    `CHK(d[3:0], 4'hf)
    wr_reg(`USBSIF_OFS_EP_FLAGS, 8'h0f);
    rd_reg(`USBSIF_OFS_EP_FLAGS, d);
    `CHK(d[3:0], 4'h0)
    wr_reg(`USBSIF_OFS_IRQ_ENABLE, 8'h00);
  endtask

  task automatic t_suspend(input logic g, input int dly);
    int c;
    wr_reg(`USBSIF_OFS_STATUS, 8'h08);
    repeat (6) @(posedge clk);
    `CHK(wake, 1'b0)
    wr_reg(`USBSIF_OFS_STATUS, 8'h00);
    wr_reg(`USBSIF_OFS_CLOCK_CTRL, 8'h01);
    glob <= g;
    c = irqs;
    host.alive <= 1'b0;
    wait_irq(c, 120);
    `CHK(irqs, c + (g ? 1 : 0))
    rd_reg(`USBSIF_OFS_STATUS, d);
    `CHK(d[1:0], 2'b01)
    wr_reg(`USBSIF_OFS_STATUS, 8'h02);
    rd_reg(`USBSIF_OFS_STATUS, d);
    `CHK(d[1:0], 2'b01)
    wr_reg(`USBSIF_OFS_CLOCK_CTRL, 8'h02);
    repeat (2) @(posedge clk);
    `CHK({low_pwr, clk_en}, 2'b10)
    glob <= 1'b1;
    host.delay <= dly;
    c = irqs;
    wr_reg(`USBSIF_OFS_STATUS, 8'h08);
    for (int i = 0; i < 8 && wake !== 1'b1; i++) @(posedge clk);
    `CHK(wake, 1'b1)
    wait_irq(c, dly + 20);
    `CHK(irqs, c + 1)
    rd_reg(`USBSIF_OFS_STATUS, d);
    `CHK(d[1:0], 2'b11)
    wr_reg(`USBSIF_OFS_STATUS, 8'h00);
    wr_reg(`USBSIF_OFS_CLOCK_CTRL, 8'h01);
    host.alive <= 1'b1;
    repeat (15) @(posedge clk);
    rd_reg(`USBSIF_OFS_STATUS, d);
    `CHK(d[1:0], 2'b00)
    `CHK({low_pwr, clk_en}, 2'b01)
  endtask

  task automatic t_reset();
    wr_reg(`USBSIF_OFS_IRQ_ENABLE, 8'h3f);
    wr_reg(`USBSIF_OFS_CLOCK_CTRL, 8'h03);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd_reg(`USBSIF_OFS_CLOCK_CTRL, d);
    `CHK(d, 8'h00)
    `CHK({low_pwr, clk_en, usb_irq, wake}, 4'h0)
    rd_reg(`USBSIF_OFS_IRQ_ENABLE, d);
    `CHK(d, 8'h00)
  endtask

  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    t_frame();
    t_endpoint();
    t_suspend(1'b1, 3);
    t_suspend(1'b0, 40);
    t_reset();
    report_and_stop();
  end
endmodule
`undef CHK
`default_nettype wire
